/* File: inc/scfd_pkg.sv */
package scfd_pkg;
    // Bit-rate selection codes
    localparam logic [3:0] SCFD_BAUD_300 = 4'h0;
    localparam logic [3:0] SCFD_BAUD_9600 = 4'h5;
    localparam logic [3:0] SCFD_BAUD_921600 = 4'hC;
    localparam int SCFD_NUM_RATES = 13;
    // Reset format byte: RS-232C, 8 bits, no parity, 1 stop
    localparam logic [7:0] SCFD_FMT_RESET = 8'h4C;
    // Field positions in the format byte
    localparam int SCFD_IF_LSB = 0;
    localparam int SCFD_LEN_LSB = 2;
    localparam int SCFD_PAR_LSB = 4;
    localparam int SCFD_STOP_LSB = 6;
    // Line interface modes
    typedef enum logic [1:0] {
        SCFD_IF_RS232 = 2'h0,
        SCFD_IF_RS422 = 2'h1,
        SCFD_IF_RS485_2W = 2'h3
    } scfd_if_type;
    // Parity modes
    typedef enum logic [1:0] {
        SCFD_PAR_NONE = 2'h0,
        SCFD_PAR_ODD = 2'h1,
        SCFD_PAR_EVEN = 2'h3
    } scfd_par_type;
    // Field codes
    localparam logic [1:0] SCFD_LEN7_CODE = 2'h2;
    localparam logic [1:0] SCFD_LEN8_CODE = 2'h3;
    localparam logic [1:0] SCFD_STOP1_CODE = 2'h1;
    localparam logic [1:0] SCFD_STOP2_CODE = 2'h3;
    localparam logic [1:0] SCFD_PARBAD_CODE = 2'h2;
    localparam logic [1:0] SCFD_IFBAD_CODE = 2'h2;
endpackage

/* File: logic/scfd_channel.sv */
`timescale 1ns/1ps
// One channel: holds and decodes its own rate and format
module scfd_channel
    import scfd_pkg::*;
(
    input wire logic sys_clk, // System clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic clk_en, // Freezes state when low, except that reset still loads defaults
    input wire logic wr_stb, // Write strobe for new settings
    input wire logic [3:0] baud_in, // Requested rate code
    input wire logic [7:0] fmt_in, // Requested format byte
    input wire logic busy, // Transmitter or receiver active
    output logic [3:0] baud_sel, // Active rate code
    output logic [7:0] fmt_byte, // Active format byte
    output logic [1:0] if_mode, // Line interface
    output logic data8, // 1 = eight data bits
    output logic [1:0] par_mode, // Parity mode
    output logic stop2, // 1 = two stop bits
    output logic fmt_err, // Last request was invalid
    output logic pend // Request waiting for idle
);
    logic pend_reg, pend_next;
    logic [3:0] pbaud_reg, pbaud_next;
    logic [7:0] pfmt_reg, pfmt_next;
    logic [3:0] baud_reg, baud_next;
    logic [7:0] fmt_reg, fmt_next;
    logic err_reg, err_next;

    // Checks each field separately, other bits play no part
    function automatic logic fmt_bad(input logic [7:0] f, input logic [3:0] b);
        logic [1:0] len, par, stp;
        len = f[SCFD_LEN_LSB +: 2];
        par = f[SCFD_PAR_LSB +: 2];
        stp = f[SCFD_STOP_LSB +: 2];
        fmt_bad = (len != SCFD_LEN7_CODE && len != SCFD_LEN8_CODE)
            || (par == SCFD_PARBAD_CODE)
            || (stp != SCFD_STOP1_CODE && stp != SCFD_STOP2_CODE)
            || (f[SCFD_IF_LSB +: 2] == SCFD_IFBAD_CODE)
            || (b > 4'(SCFD_NUM_RATES - 1));
    endfunction

    // Next state: capture request, apply only when idle
    always_comb begin
        pend_next = pend_reg;
        pbaud_next = pbaud_reg;
        pfmt_next = pfmt_reg;
        baud_next = baud_reg;
        fmt_next = fmt_reg;
        err_next = err_reg;
        if (wr_stb) begin
            if (fmt_bad(fmt_in, baud_in)) begin
                err_next = 1'b1;
                pend_next = 1'b0; // Old framing kept
            end else begin
                err_next = 1'b0;
                pend_next = 1'b1;
                pbaud_next = baud_in;
                pfmt_next = fmt_in;
            end
        end else if (pend_reg && !busy) begin
            // Switching mid-character would mix framing
            baud_next = pbaud_reg;
            fmt_next = pfmt_reg;
            pend_next = 1'b0;
        end
    end

    // Registers, defaults restored on reset
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pend_reg <= 1'b0;
            pbaud_reg <= SCFD_BAUD_9600;
            pfmt_reg <= SCFD_FMT_RESET;
            baud_reg <= SCFD_BAUD_9600;
            fmt_reg <= SCFD_FMT_RESET;
            err_reg <= 1'b0;
        end else if (clk_en) begin
            pend_reg <= pend_next;
            pbaud_reg <= pbaud_next;
            pfmt_reg <= pfmt_next;
            baud_reg <= baud_next;
            fmt_reg <= fmt_next;
            err_reg <= err_next;
        end
    end

    // Decoded outputs, each from its own field only
    assign baud_sel = baud_reg;
    assign fmt_byte = fmt_reg;
    assign if_mode = fmt_reg[SCFD_IF_LSB +: 2];
    // Only legal codes are ever stored, so one register bit tells them apart
    assign data8 = fmt_reg[SCFD_LEN_LSB];
    assign par_mode = fmt_reg[SCFD_PAR_LSB +: 2];
    assign stop2 = fmt_reg[SCFD_STOP_LSB + 1];
    assign fmt_err = err_reg;
    assign pend = pend_reg;
endmodule

/* File: logic/scfd_top.sv */
`timescale 1ns/1ps
module scfd_top
    import scfd_pkg::*;
#(
    parameter int NCH = 2 // Number of channels
) (
    input wire logic sys_clk, // 200 MHz clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic clk_en, // Freezes state when low, except that reset still loads defaults
    input wire logic [NCH-1:0] wr_stb, // Per-channel write strobe
    input wire logic [4*NCH-1:0] baud_in, // Rate codes, 4 bits each
    input wire logic [8*NCH-1:0] fmt_in, // Format bytes
    input wire logic [NCH-1:0] busy, // Per-channel UART activity
    output logic [4*NCH-1:0] baud_sel, // Active rate codes
    output logic [8*NCH-1:0] fmt_byte, // Active format bytes
    output logic [2*NCH-1:0] if_mode, // Line interface per channel
    output logic [NCH-1:0] data8, // Eight data bits
    output logic [2*NCH-1:0] par_mode, // Parity mode per channel
    output logic [NCH-1:0] stop2, // Two stop bits
    output logic [NCH-1:0] fmt_err, // Invalid request flag
    output logic [NCH-1:0] pend // Request waiting for idle
);
    // One instance per channel, no shared state
    genvar i;
    generate
        for (i = 0; i < NCH; i++) begin : g_ch
            scfd_channel u_ch (
                .sys_clk(sys_clk),
                .rstn(rstn),
                .clk_en(clk_en),
                .wr_stb(wr_stb[i]),
                .baud_in(baud_in[4*i +: 4]),
                .fmt_in(fmt_in[8*i +: 8]),
                .busy(busy[i]),
                .baud_sel(baud_sel[4*i +: 4]),
                .fmt_byte(fmt_byte[8*i +: 8]),
                .if_mode(if_mode[2*i +: 2]),
                .data8(data8[i]),
                .par_mode(par_mode[2*i +: 2]),
                .stop2(stop2[i]),
                .fmt_err(fmt_err[i]),
                .pend(pend[i])
            );
        end
    endgenerate
endmodule

/* File: testbench/scfd_checker.sv */
`timescale 1ns/1ps
// Channel 0 decode and handshake, channel 1 isolation
module scfd_checker
    import scfd_pkg::*;
#(parameter int NCH = 2) (
    input wire logic sys_clk, rstn, clk_en, // Clock, reset, enable
    input wire logic [NCH-1:0] wr_stb, busy, data8, stop2, fmt_err, pend, // Per channel
    input wire logic [4*NCH-1:0] baud_in, baud_sel, // Rate codes
    input wire logic [8*NCH-1:0] fmt_in, fmt_byte, // Format bytes
    input wire logic [2*NCH-1:0] if_mode, par_mode // Two-bit fields
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Legal request and its acceptance
    wire ok0 = fmt_in[3] && fmt_in[6] && fmt_in[5:4] != 2'h2 && fmt_in[1:0] != 2'h2 && baud_in[3:0] <= 4'hC;
    wire tk0 = clk_en && wr_stb[0];
    property p_if; if_mode[1:0] == fmt_byte[1:0]; endproperty
    a_if: assert property (p_if) else $error("interface decode");
    property p_ls; data8[0] == fmt_byte[2] && stop2[0] == fmt_byte[7]; endproperty
    a_ls: assert property (p_ls) else $error("length or stop decode");
    property p_par; par_mode[1:0] == fmt_byte[5:4]; endproperty
    a_par: assert property (p_par) else $error("parity decode");
    // Checked through reset itself, so no disable here
    property p_rst; disable iff (1'b0) !rstn && clk_en |=> fmt_byte[7:0] == 8'h4C && baud_sel[3:0] == 4'h5; endproperty
    a_rst: assert property (p_rst) else $error("reset settings");
    property p_stall; busy[0] |=> $stable(fmt_byte[7:0]) && $stable(baud_sel[3:0]); endproperty
    a_stall: assert property (p_stall) else $error("change while busy");
    property p_bad; tk0 && !ok0 |=> fmt_err[0] && !pend[0] && $stable(fmt_byte[7:0]); endproperty
    a_bad: assert property (p_bad) else $error("bad request taken");
    property p_good; tk0 && ok0 |=> pend[0] && !fmt_err[0]; endproperty
    a_good: assert property (p_good) else $error("good request refused");
    property p_iso; !pend[1] |=> $stable(fmt_byte[15:8]) && $stable(baud_sel[7:4]); endproperty
    a_iso: assert property (p_iso) else $error("channel 1 disturbed");
    c_bad: cover property (tk0 && !ok0);
    c_stall: cover property (pend[0] && busy[0]);
    c_apply: cover property (pend[0] ##1 !pend[0]);
endmodule

/* File: testbench/scfd_test.sv */
`timescale 1ns/1ps
module scfd_test import scfd_pkg::*;;
    logic sys_clk = 0, rstn = 0, clk_en = 1; // Clock, reset, enable
    logic [1:0] wr_stb = 0, stall = 0, busy, data8, stop2, fmt_err, pend; // Per channel
    logic [7:0] baud_in = 8'h55, baud_sel; // Rate codes
    logic [15:0] fmt_in = 16'h4C4C, fmt_byte; // Format bytes
    logic [3:0] if_mode, par_mode; // Two-bit fields
    int n_fail = 0, n_checks = 0; // Tallies
    // Rows: format, rate, then expected if, data8, parity, stop2
    logic [17:0] rows [4] = '{{8'h4C, 4'h0, 6'h08}, {8'h78, 4'hC, 6'h06}, {8'hDD, 4'hA, 6'h1B}, {8'h4F, 4'hB, 6'h38}};
    scfd_top #(.NCH(2)) DUT (.*);
    scfd_uart_model model (.sys_clk, .rstn, .stall, .busy);
    initial forever #2.5 sys_clk = ~sys_clk;
    task automatic chk(logic [15:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One write on channel 0, then time to apply
    task automatic wr(logic [7:0] f, logic [3:0] b);
        @(posedge sys_clk);
        fmt_in[7:0] <= f;
        baud_in[3:0] <= b;
        wr_stb[0] <= 1'b1;
        @(posedge sys_clk);
        wr_stb[0] <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic results;
        $display("checks %0d, failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        #1;
        chk({baud_sel, fmt_byte[7:0]}, 16'h554C);
        foreach (rows[i]) begin
            wr(rows[i][17:10], rows[i][9:6]);
            chk({if_mode[1:0], data8[0], par_mode[1:0], stop2[0]}, rows[i][5:0]);
            chk({fmt_byte[7:0], baud_sel[3:0]}, rows[i][17:6]);
        end
        // Held while the UART is active
        @(posedge sys_clk);
        stall <= 2'h1;
        wr(8'hCB, 4'h5);
        chk({pend[0], fmt_byte[7:0]}, 16'h014F);
        @(posedge sys_clk);
        stall <= 2'h0;
        repeat (3) @(posedge sys_clk);
        #1;
        chk({pend[0], fmt_byte[7:0]}, 16'h00CB);
        wr(8'h44, 4'h9);
        chk({fmt_err[0], pend[0], fmt_byte[7:0], baud_sel[3:0]}, 16'h2CB5);
        wr(8'h4C, 4'hD);
        chk({fmt_err[0], pend[0], fmt_byte[7:0], baud_sel[3:0]}, 16'h2CB5);
        chk({fmt_byte[15:8], baud_sel[7:4], fmt_err[1]}, 16'h098A);
        // Frozen while the enable is low, strobe is lost
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr(8'h78, 4'h3);
        chk({fmt_err[0], pend[0], fmt_byte[7:0], baud_sel[3:0]}, 16'h2CB5);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        // Second reset in mid-run
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        #1;
        chk(fmt_byte, 16'h4C4C);
        chk({baud_sel, fmt_err, pend}, 16'h0550);
        results;
    end
    // Hang guard, well past the expected run
    initial begin
        repeat (400) @(posedge sys_clk);
        n_fail++;
        results;
    end
endmodule
bind scfd_top scfd_checker #(.NCH(NCH)) u_chk (.*);

/* File: testbench/scfd_uart_model.sv */
`timescale 1ns/1ps
// Far-side UART activity, idle while in reset
module scfd_uart_model (
    input wire logic sys_clk, // Clock
    input wire logic rstn, // Reset
    input wire logic [1:0] stall, // Keep the line busy
    output logic [1:0] busy // UART active
);
    // Registered so busy moves just after an edge
    always_ff @(posedge sys_clk) busy <= rstn ? stall : 2'h0;
endmodule
